// ### design/ssbc_pkg.sv
package ssbc_pkg;

   // ==========================================================
   // Geometry
   // ==========================================================
   localparam int SSBC_ADDR_W = 18;
   localparam int SSBC_LANES_WIDE = 4;
   localparam int SSBC_LANES_NARROW = 2;
   localparam int SSBC_BURST_W = 2;
   localparam logic SSBC_CFG_WIDE = 1'b1;

   // ==========================================================
   // Burst counter values
   // ==========================================================
   localparam logic [1:0] SSBC_COUNT_START = 2'h0;
   localparam logic [1:0] SSBC_COUNT_STEP = 2'h1;
   localparam logic [1:0] SSBC_START_RESET = 2'h0;

   // ==========================================================
   // Cycle kinds decoded from the strobes
   // ==========================================================
   typedef enum logic [2:0] {
      SSBC_CYC_DESELECT,
      SSBC_CYC_BEGIN_RD,
      SSBC_CYC_BEGIN_WR,
      SSBC_CYC_CONT_RD,
      SSBC_CYC_CONT_WR,
      SSBC_CYC_SUSP_RD,
      SSBC_CYC_SUSP_WR
   } ssbc_cyc_e;

   // Low address bits for a burst position
   function automatic logic [1:0] ssbc_burst_lo(input logic [1:0] start,
                                                input logic [1:0] count,
                                                input logic interleave);
      logic [1:0] sum;
      sum = 2'(start + count);
      return interleave ? (start ^ count) : sum;
   endfunction

endpackage

// ### design/ssbc_write_decode.sv
`timescale 1ns/1ps
module ssbc_write_decode
   import ssbc_pkg::*;
#(
   parameter int LANES = SSBC_LANES_WIDE
) (
   input wire logic global_write_n,
   input wire logic byte_write_n,
   input wire logic [LANES-1:0] lane_write_n,
   output logic is_write,
   output logic [LANES-1:0] lane_strobe
);

   // ==========================================================
   // Write decode
   // ==========================================================
   wire any_lane = ~&lane_write_n;
   wire byte_mode = ~byte_write_n & any_lane;

   assign is_write = ~global_write_n | byte_mode;
   assign lane_strobe = ~global_write_n ? {LANES{1'b1}} :
                        (byte_mode ? ~lane_write_n : {LANES{1'b0}});

endmodule // ssbc_write_decode

// ### design/ssbc_burst_counter.sv
`timescale 1ns/1ps
module ssbc_burst_counter
   import ssbc_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic load,
   input wire logic step,
   input wire logic [1:0] start_in,
   input wire logic interleave,
   output logic [1:0] lo_now,
   output logic [1:0] lo_next
);

   logic [1:0] start_q;
   logic [1:0] count_q;
   logic [1:0] count_inc;

   // ==========================================================
   // Burst position
   // ==========================================================
   assign count_inc = 2'(count_q + SSBC_COUNT_STEP);
   assign lo_now = ssbc_burst_lo(start_q, count_q, interleave);
   assign lo_next = ssbc_burst_lo(start_q, count_inc, interleave);

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         start_q <= SSBC_START_RESET;
         count_q <= SSBC_COUNT_START;
      end else if (load) begin
         start_q <= start_in;
         count_q <= SSBC_COUNT_START;
      end else if (step) begin
         count_q <= count_inc;
      end
   end

endmodule // ssbc_burst_counter

// ### design/ssbc_core.sv
`timescale 1ns/1ps
module ssbc_core
   import ssbc_pkg::*;
#(
   parameter int ADDR_W = SSBC_ADDR_W,
   parameter logic WIDE = SSBC_CFG_WIDE,
   localparam int LANES = WIDE ? SSBC_LANES_WIDE : SSBC_LANES_NARROW
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic chip_select_low,
   input wire logic chip_select_high,
   input wire logic cpu_address_strobe_n,
   input wire logic controller_address_strobe_n,
   input wire logic burst_step_n,
   input wire logic global_write_n,
   input wire logic byte_write_n,
   input wire logic byte_lane_a_write_n,
   input wire logic byte_lane_b_write_n,
   input wire logic byte_lane_c_write_n,
   input wire logic byte_lane_d_write_n,
   input wire logic sequential_order_select_n,
   input wire logic parity_io_enable_n,
   input wire logic output_enable_n,
   output logic [ADDR_W-1:0] array_addr_q,
   output logic array_read_q,
   output logic array_write_q,
   output logic [LANES-1:0] lane_write_q,
   output logic [LANES-1:0] data_oe_n_q,
   output logic [LANES-1:0] parity_oe_n_q,
   output logic parity_io_active_q,
   output logic deselect_q
);

   // ==========================================================
   // Lane enables
   // ==========================================================
   logic [SSBC_LANES_WIDE-1:0] all_lanes_n;
   logic [LANES-1:0] lane_n;
   logic is_write;
   logic [LANES-1:0] lane_strobe;

   assign all_lanes_n = {byte_lane_d_write_n, byte_lane_c_write_n,
                         byte_lane_b_write_n, byte_lane_a_write_n};
   // Narrow part only sees lanes a and b
   assign lane_n = all_lanes_n[LANES-1:0];

   ssbc_write_decode #(
      .LANES(LANES)
   ) u_wdec (
      .global_write_n(global_write_n),
      .byte_write_n(byte_write_n),
      .lane_write_n(lane_n),
      .is_write(is_write),
      .lane_strobe(lane_strobe)
   );

   // ==========================================================
   // Cycle decode
   // ==========================================================
   wire high_sel_true = WIDE ? chip_select_high : 1'b1;
   wire selected = ~chip_select_low & high_sel_true;
   wire any_strobe = ~cpu_address_strobe_n | ~controller_address_strobe_n;
   wire desel_a = chip_select_low & ~controller_address_strobe_n;
   wire desel_b = ~chip_select_low & ~high_sel_true & any_strobe;
   wire begin_rd = selected & (~cpu_address_strobe_n |
                   (~controller_address_strobe_n & ~is_write));
   wire begin_wr = selected & cpu_address_strobe_n &
                   ~controller_address_strobe_n & is_write;
   wire keep_on = controller_address_strobe_n &
                  (cpu_address_strobe_n | chip_select_low);
   wire cont = keep_on & ~burst_step_n;
   wire susp = keep_on & burst_step_n;
   wire interleave = sequential_order_select_n;

   ssbc_cyc_e cyc;

   always_comb begin
      if (desel_a || desel_b) begin
         cyc = SSBC_CYC_DESELECT;
      end else if (begin_rd) begin
         cyc = SSBC_CYC_BEGIN_RD;
      end else if (begin_wr) begin
         cyc = SSBC_CYC_BEGIN_WR;
      end else if (cont) begin
         cyc = is_write ? SSBC_CYC_CONT_WR : SSBC_CYC_CONT_RD;
      end else if (susp) begin
         cyc = is_write ? SSBC_CYC_SUSP_WR : SSBC_CYC_SUSP_RD;
      end else begin
         cyc = SSBC_CYC_DESELECT;
      end
   end

   // ==========================================================
   // Burst counter
   // ==========================================================
   logic [1:0] lo_now;
   logic [1:0] lo_next;
   wire cyc_begin = (cyc == SSBC_CYC_BEGIN_RD) || (cyc == SSBC_CYC_BEGIN_WR);
   wire cyc_cont = (cyc == SSBC_CYC_CONT_RD) || (cyc == SSBC_CYC_CONT_WR);

   // Output enable is not looked at: dummy reads step too
   ssbc_burst_counter u_cnt (
      .mclk(mclk),
      .rstn(rstn),
      .load(cyc_begin),
      .step(cyc_cont),
      .start_in(addr_in[SSBC_BURST_W-1:0]),
      .interleave(interleave),
      .lo_now(lo_now),
      .lo_next(lo_next)
   );

   // ==========================================================
   // Next array access
   // ==========================================================
   logic [ADDR_W-1:0] array_addr_d;
   logic array_read_d;
   logic array_write_d;
   logic [LANES-1:0] lane_write_d;
   logic [LANES-1:0] drive_n_d;
   logic [ADDR_W-1:0] next_addr;
   logic [ADDR_W-1:0] same_addr;

   // Array address with its low bits replaced by a burst position
   function automatic logic [ADDR_W-1:0] burst_addr(input logic [ADDR_W-1:0] base,
                                                     input logic [SSBC_BURST_W-1:0] lo);
      return {base[ADDR_W-1:SSBC_BURST_W], lo};
   endfunction

   assign next_addr = burst_addr(array_addr_q, lo_next);
   assign same_addr = burst_addr(array_addr_q, lo_now);

   // Every cycle kind sets all four access values
   always_comb begin
      array_addr_d = array_addr_q;
      array_read_d = 1'b0;
      array_write_d = 1'b0;
      lane_write_d = '0;
      case (cyc)
         SSBC_CYC_DESELECT: begin
            array_addr_d = array_addr_q;
            array_read_d = 1'b0;
            array_write_d = 1'b0;
            lane_write_d = '0;
         end
         SSBC_CYC_BEGIN_RD: begin
            array_addr_d = addr_in;
            array_read_d = 1'b1;
            array_write_d = 1'b0;
            lane_write_d = '0;
         end
         SSBC_CYC_BEGIN_WR: begin
            array_addr_d = addr_in;
            array_read_d = 1'b0;
            array_write_d = 1'b1;
            lane_write_d = lane_strobe;
         end
         SSBC_CYC_CONT_RD: begin
            array_addr_d = next_addr;
            array_read_d = 1'b1;
            array_write_d = 1'b0;
            lane_write_d = '0;
         end
         SSBC_CYC_CONT_WR: begin
            array_addr_d = next_addr;
            array_read_d = 1'b0;
            array_write_d = 1'b1;
            lane_write_d = lane_strobe;
         end
         SSBC_CYC_SUSP_RD: begin
            array_addr_d = same_addr;
            array_read_d = 1'b1;
            array_write_d = 1'b0;
            lane_write_d = '0;
         end
         SSBC_CYC_SUSP_WR: begin
            array_addr_d = same_addr;
            array_read_d = 1'b0;
            array_write_d = 1'b1;
            lane_write_d = lane_strobe;
         end
         default: begin
            array_addr_d = array_addr_q;
            array_read_d = 1'b0;
            array_write_d = 1'b0;
            lane_write_d = '0;
         end
      endcase
   end

   // Reads drive all lanes; writes and deselects float them
   assign drive_n_d = array_read_d ? {LANES{1'b0}} : {LANES{1'b1}};

   // ==========================================================
   // Status next values
   // ==========================================================
   logic deselect_d;
   logic parity_io_active_d;
   logic [LANES-1:0] parity_oe_n_d;
   assign deselect_d = (cyc == SSBC_CYC_DESELECT);
   assign parity_io_active_d = ~parity_io_enable_n;
   assign parity_oe_n_d = drive_n_d | {LANES{parity_io_enable_n}};

   // ==========================================================
   // Array access registers
   // ==========================================================
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         array_addr_q <= '0;
      end else begin
         array_addr_q <= array_addr_d;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         array_read_q <= 1'b0;
      end else begin
         array_read_q <= array_read_d;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         array_write_q <= 1'b0;
      end else begin
         array_write_q <= array_write_d;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         lane_write_q <= '0;
      end else begin
         lane_write_q <= lane_write_d;      // Ninth storage bit follows lane
      end
   end

   // ==========================================================
   // Status registers
   // ==========================================================
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         deselect_q <= 1'b1;
      end else begin
         deselect_q <= deselect_d;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         parity_io_active_q <= 1'b0;
      end else begin
         parity_io_active_q <= parity_io_active_d;
      end
   end

   // ==========================================================
   // Output drivers
   // ==========================================================
   // Output enable high sets the disable flops at once
   wire drive_kill = ~rstn | output_enable_n;

   always_ff @(posedge mclk or posedge drive_kill) begin
      if (drive_kill) begin
         data_oe_n_q <= '1;
      end else begin
         data_oe_n_q <= drive_n_d;
      end
   end

   always_ff @(posedge mclk or posedge drive_kill) begin
      if (drive_kill) begin
         parity_oe_n_q <= '1;
      end else begin
         parity_oe_n_q <= parity_oe_n_d;
      end
   end

endmodule // ssbc_core

// ### testbench/ssbc_core_monitor.sv
`timescale 1ns/1ps
module ssbc_core_monitor
   import ssbc_pkg::*;
#(
   parameter int ADDR_W = SSBC_ADDR_W,
   parameter logic WIDE = SSBC_CFG_WIDE,
   localparam int LANES = WIDE ? SSBC_LANES_WIDE : SSBC_LANES_NARROW
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic chip_select_low,
   input wire logic chip_select_high,
   input wire logic cpu_address_strobe_n,
   input wire logic controller_address_strobe_n,
   input wire logic burst_step_n,
   input wire logic global_write_n,
   input wire logic sequential_order_select_n,
   input wire logic parity_io_enable_n,
   input wire logic output_enable_n,
   input wire logic [ADDR_W-1:0] array_addr_q,
   input wire logic array_read_q,
   input wire logic array_write_q,
   input wire logic [LANES-1:0] lane_write_q,
   input wire logic [LANES-1:0] data_oe_n_q,
   input wire logic [LANES-1:0] parity_oe_n_q,
   input wire logic parity_io_active_q,
   input wire logic deselect_q
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   wire logic sel = !chip_select_low && (chip_select_high || !WIDE);
   wire logic go = sel && !(cpu_address_strobe_n && controller_address_strobe_n);
   wire logic hold = controller_address_strobe_n && (cpu_address_strobe_n || chip_select_low);
   sequence s_begin;
      go;
   endsequence
   sequence s_cont;
      !deselect_q && hold && $stable(sequential_order_select_n);
   endsequence
   AST_BEGIN_ADDR: assert property (s_begin |=> array_addr_q == $past(addr_in))
      else $error("begin address not loaded");
   AST_GW_ALL: assert property (s_begin ##0 cpu_address_strobe_n && !global_write_n
      |=> array_write_q && &lane_write_q) else $error("global write missed lanes");
   AST_WRITE_HIZ: assert property (array_write_q |-> &data_oe_n_q && &parity_oe_n_q)
      else $error("drivers on during write");
   AST_OE_OFF: assert property (output_enable_n |-> &data_oe_n_q && &parity_oe_n_q)
      else $error("drivers on with output enable high");
   AST_CPU_READ: assert property (s_begin ##0 !cpu_address_strobe_n && !output_enable_n
      ##1 !output_enable_n |-> array_read_q && data_oe_n_q == '0) else $error("read not driven");
   AST_DESELECT: assert property (chip_select_low && !controller_address_strobe_n
      |=> deselect_q && !array_read_q && !array_write_q) else $error("deselect missed");
   AST_SUSPEND: assert property (s_cont ##0 burst_step_n |=> $stable(array_addr_q))
      else $error("suspend moved address");
   AST_LINEAR: assert property (s_cont ##0 !burst_step_n && !sequential_order_select_n
      |=> array_addr_q[1:0] == 2'($past(array_addr_q[1:0]) + 2'h1)) else $error("linear step");
   AST_PARITY: assert property (parity_io_enable_n |=> !parity_io_active_q && &parity_oe_n_q)
      else $error("ninth line active while disabled");
endmodule // ssbc_core_monitor

bind ssbc_core ssbc_core_monitor #(.ADDR_W(ADDR_W), .WIDE(WIDE)) u_monitor (.*);

// ### testbench/ssbc_host_model.sv
`timescale 1ns/1ps
module ssbc_host_model (
   input wire logic mclk,
   output logic [17:0] addr_in,
   output logic chip_select_low,
   output logic chip_select_high,
   output logic cpu_address_strobe_n,
   output logic controller_address_strobe_n,
   output logic burst_step_n,
   output logic global_write_n,
   output logic byte_write_n,
   output logic [3:0] lane_write_n,
   output logic sequential_order_select_n,
   output logic parity_io_enable_n,
   output logic output_enable_n
);
   initial begin
      {chip_select_low, cpu_address_strobe_n, controller_address_strobe_n} = 3'h7;
      {burst_step_n, global_write_n, byte_write_n, lane_write_n, output_enable_n} = 8'hff;
      {chip_select_high, sequential_order_select_n, parity_io_enable_n} = 3'h0;
      addr_in = 18'h0;
   end
   // ==========================================
   // One bus cycle: 0 free, 1 single, 2 burst
   task automatic bus_cycle(input int mode);
      @(posedge mclk);
      addr_in <= 18'($urandom);
      chip_select_low <= ($urandom_range(0, 7) == 0);
      chip_select_high <= ($urandom_range(0, 7) != 0);
      cpu_address_strobe_n <= (mode != 0) || ($urandom_range(0, 3) != 0);
      controller_address_strobe_n <= (mode != 1) && ($urandom_range(0, 2) != 0);
      burst_step_n <= (mode != 2) && ($urandom_range(0, 3) == 0);
      global_write_n <= ($urandom_range(0, 3) != 0);
      byte_write_n <= 1'($urandom);
      lane_write_n <= 4'($urandom);
      output_enable_n <= ($urandom_range(0, 7) == 0);
      if ($urandom_range(0, 15) == 0) sequential_order_select_n <= !sequential_order_select_n;
      if ($urandom_range(0, 15) == 0) parity_io_enable_n <= !parity_io_enable_n;
   endtask
endmodule // ssbc_host_model

// ### testbench/ssbc_core_tb.sv
`timescale 1ns/1ps
module ssbc_core_tb;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   int failures = 0;
   int total_checks = 0;
   logic [17:0] addr_in, array_addr_q, e_addr;
   logic chip_select_low, chip_select_high, cpu_address_strobe_n, controller_address_strobe_n;
   logic burst_step_n, global_write_n, byte_write_n, sequential_order_select_n;
   logic parity_io_enable_n, output_enable_n, array_read_q, array_write_q;
   logic parity_io_active_q, deselect_q, e_rd, e_wr, e_des, e_drv, e_act;
   logic [3:0] lane_write_n, lane_write_q, data_oe_n_q, parity_oe_n_q, e_ln;
   logic [1:0] st, cnt;
   logic [15:0] hi;
   always #12.5 mclk = ~mclk;
   // Lanes written in one cycle; none means a read
   function automatic logic [3:0] exp_lanes(input logic gw_n, input logic bw_n,
                                            input logic [3:0] ln_n);
      return !gw_n ? 4'hf : (bw_n ? 4'h0 : ~ln_n);
   endfunction
   // Low address bits of a burst position
   function automatic logic [1:0] exp_lo(input logic ilv, input logic [1:0] s,
                                         input logic [1:0] c);
      return ilv ? (s ^ c) : 2'(s + c);
   endfunction
   ssbc_host_model host (.*);
   ssbc_core uut (.byte_lane_a_write_n(lane_write_n[0]), .byte_lane_b_write_n(lane_write_n[1]),
      .byte_lane_c_write_n(lane_write_n[2]), .byte_lane_d_write_n(lane_write_n[3]), .*);
   // ==========================================
   // Reference of the cycle decode
   always @(posedge mclk or negedge rstn) begin : ref_model
      logic sel, go, hold, wr;
      logic [3:0] ln;
      if (!rstn) begin
         {st, cnt, hi, e_rd, e_wr, e_drv, e_act, e_ln} = '0;
         e_des = 1'b1;
      end else begin
         ln = exp_lanes(global_write_n, byte_write_n, lane_write_n);
         wr = |ln;
         sel = !chip_select_low && chip_select_high;
         go = sel && !(cpu_address_strobe_n && controller_address_strobe_n);
         hold = controller_address_strobe_n && (cpu_address_strobe_n || chip_select_low);
         e_des = !go && !hold;
         if (go) {hi, st, cnt} = {addr_in, 2'h0};
         else if (hold && !burst_step_n) cnt = cnt + 2'h1;
         e_addr = {hi, exp_lo(sequential_order_select_n, st, cnt)};
         e_wr = wr && (hold || cpu_address_strobe_n) && !e_des;
         e_rd = !e_des && !e_wr;
         e_ln = e_wr ? ln : 4'h0;
         e_drv = e_rd && !output_enable_n;
         e_act = !parity_io_enable_n;
      end
   end
   task automatic chk(input string n, input logic [17:0] e, input logic [17:0] g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   always @(negedge mclk) begin
      if (rstn) begin
         if (!e_des) chk("addr", e_addr, array_addr_q);
         chk("deselect", 18'(e_des), 18'(deselect_q));
         chk("read", 18'(e_rd), 18'(array_read_q));
         chk("write", 18'(e_wr), 18'(array_write_q));
         chk("lanes", 18'(e_ln), 18'(lane_write_q));
         chk("data_oe", 18'({4{!(e_drv && !output_enable_n)}}), 18'(data_oe_n_q));
         chk("par_oe", 18'({4{!(e_drv && e_act && !output_enable_n)}}), 18'(parity_oe_n_q));
         chk("par_act", 18'(e_act), 18'(parity_io_active_q));
      end
   end
   // Begin at a start, five steps, wrap, then output enable raised
   task automatic burst(input logic order, input logic [17:0] start);
      @(posedge mclk);
      host.sequential_order_select_n <= order;
      host.chip_select_low <= 1'b0;
      host.chip_select_high <= 1'b1;
      host.cpu_address_strobe_n <= 1'b0;
      host.addr_in <= start;
      host.output_enable_n <= 1'b0;
      repeat (5) begin
         @(posedge mclk);
         host.cpu_address_strobe_n <= 1'b1;
         host.controller_address_strobe_n <= 1'b1;
         host.burst_step_n <= 1'b0;
      end
      @(posedge mclk);
      host.output_enable_n <= 1'b1;
   endtask
   task automatic print_verdict();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #200000;
      failures++;
      $display("MISMATCH watchdog expected done seen timeout");
      print_verdict();
   end
   initial begin
      void'($urandom(32'h1f40));
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      burst(1'b0, 18'h00006);
      burst(1'b1, 18'h00005);
      $display("test bursts done");
      for (int m = 0; m < 3; m++) begin
         repeat (600) host.bus_cycle(m);
         $display("test random mode %0d done", m);
      end
      rstn <= 1'b0;
      @(posedge mclk);
      rstn <= 1'b1;
      repeat (300) host.bus_cycle(0);
      $display("test reset in mid-run done");
      print_verdict();
   end
endmodule // ssbc_core_tb
